/* logic/ptt_ctrl.sv */
/*
  Termination decision logic of a dual-protocol wireless power receiver: reason selection,
  output and adapter switch control, rectifier boost pins, communication current limit.
  Assumes all comparator inputs are digitised and synchronous to clk.
*/
`timescale 1ns/1ps
`include "ptt_params.svh"
// Operation
// - Packet mode sends reason codes 0x00 to 0x04
// - Never emit reason codes 0x05 to 0x08
// - Junction hot or low limit resistor: fault; the code raises it in packet mode only
// - Hot sense or control pin low: over temperature
// - No rectifier target after 64 packets: over voltage
// - Sense pin high sends charge complete
// - Adapter present: output off, switches closed
// - Symbol mode: termination above limit sense ends
// - Boost outputs follow output current bands
// - Boost role only with termination resistor present
// - Packet mode: select pin low enables limit
// - Limit bands: none, plus 50, minus 50
// - Limit applies only while a packet is sent
// - Default setting regulates feedback to 0.5 V
// - Symbol mode uses six defined symbols
// - Packets use bi-phase coding at 2 kb/s
module ptt_ctrl #(
  parameter int HALF_BIT_CYCLES = `PTT_HALF_BIT_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic packet_mode,
  input wire logic startup_done,
  input wire logic cep_sent,
  input wire logic rectifier_node_at_target,
  input wire logic adapter_above_enable,
  input wire logic temp_sense_high,
  input wire logic control_pin_high,
  input wire logic control_pin_low,
  input wire logic junction_over_150c,
  input wire logic limit_resistor_low,
  input wire logic temp_sense_hot,
  input wire logic term_above_limit_sense,
  input wire logic term_resistor_present,
  input wire logic iout_above_100ma,
  input wire logic iout_above_350ma,
  input wire logic iout_above_400ma,
  input wire logic comm_current_limit_select,
  input wire logic pad_present,
  input wire logic reg_write,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic [2:0] output_voltage_feedback,
  output logic output_enable,
  output logic adapter_switch_enable,
  output logic control_packets_enable,
  output logic low_power_boost_a,
  output logic low_power_boost_b,
  output logic comm_limit_enable,
  output logic comm_limit_minus,
  output logic mod_level,
  output logic symbol_strobe,
  output logic [2:0] symbol_code,
  output logic terminated,
  output logic [7:0] end_power_transfer
);
  ptt_tx_if tx_bus ();
  ptt_pkg::ptt_state_type state;
  logic [7:0] output_voltage_setting;
  logic [6:0] cep_count;
  logic ov_flag;
  logic adapter_cause;
  logic cond_adapter;
  logic cond_charged;
  logic cond_fault;
  logic cond_hot;
  logic cond_term;
  logic any_cond;
  logic [7:0] next_reason;
  logic start_pulse;

  ptt_tx #(
    .HALF_BIT_CYCLES(HALF_BIT_CYCLES)
  ) u_tx (
    .clk(clk),
    .reset_n(reset_n),
    .bus(tx_bus),
    .mod_level(mod_level),
    .symbol_strobe(symbol_strobe),
    .symbol_code(symbol_code)
  );

  // Register port: only the output voltage setting is implemented here
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      output_voltage_setting <= `PTT_VOUT_SET_RESET;
    end else if (reg_write && reg_addr == `PTT_REG_VOUT_SET) begin
      output_voltage_setting <= reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
      output_voltage_feedback <= 3'(`PTT_VOUT_SET_RESET);
    end else begin
      if (reg_addr == `PTT_REG_VOUT_SET) begin
        reg_rdata <= output_voltage_setting;
      end else begin
        reg_rdata <= 8'h00;
      end
      // Regulation reference code; the reset code targets 0.5 V at the feedback pin
      output_voltage_feedback <= output_voltage_setting[`PTT_VOUT_FIELD_MSB:`PTT_VOUT_FIELD_LSB];
    end
  end

  // Startup convergence watch; counting stops once the flag is raised
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cep_count <= 7'h00;
      ov_flag <= 1'b0;
    end else if (!startup_done && !rectifier_node_at_target && cep_sent && !ov_flag) begin
      cep_count <= cep_count + 7'h01;
      if (cep_count + 7'h01 >= `PTT_STARTUP_CEP_LIMIT) begin
        ov_flag <= 1'b1;
      end
    end
  end

  assign cond_adapter = adapter_above_enable;
  // Host drives the control pin for charge complete when the boost role is absent
  assign cond_charged = temp_sense_high || (!term_resistor_present && control_pin_high);
  assign cond_fault = junction_over_150c || limit_resistor_low;
  assign cond_hot = temp_sense_hot || control_pin_low;
  assign cond_term = !packet_mode && term_above_limit_sense;

  // Fixed priority: adapter, charged, fault, over temperature, over voltage, then symbol-mode termination as charged; codes above 0x04 are unreachable
  always_comb begin
    next_reason = `PTT_REASON_ADAPTER;
    any_cond = 1'b1;
    if (cond_adapter) begin
      next_reason = `PTT_REASON_ADAPTER;
    end else if (cond_charged) begin
      next_reason = `PTT_REASON_CHARGED;
    end else if (cond_fault && packet_mode) begin
      next_reason = `PTT_REASON_FAULT;
    end else if (cond_hot) begin
      next_reason = `PTT_REASON_OVER_TEMP;
    end else if (ov_flag && packet_mode) begin
      next_reason = `PTT_REASON_OVER_VOLT;
    end else if (cond_term) begin
      next_reason = `PTT_REASON_CHARGED;
    end else begin
      any_cond = 1'b0;
    end
  end

  assign start_pulse = (state == ptt_pkg::ptt_run) && any_cond;
  assign tx_bus.start = start_pulse;
  assign tx_bus.packet_mode = packet_mode;
  assign tx_bus.reason = next_reason;
  assign tx_bus.symbol = `PTT_SYM_EOC;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state <= ptt_pkg::ptt_run;
      end_power_transfer <= 8'h00;
      adapter_cause <= 1'b0;
    end else begin
      case (state)
        ptt_pkg::ptt_run: begin
          if (any_cond) begin
            end_power_transfer <= next_reason;
            adapter_cause <= cond_adapter;
            state <= ptt_pkg::ptt_send;
          end
        end
        ptt_pkg::ptt_send: begin
          if (tx_bus.done) begin
            state <= ptt_pkg::ptt_done;
          end
        end
        // Only reset leaves this state
        ptt_pkg::ptt_done: state <= ptt_pkg::ptt_done;
        default: state <= ptt_pkg::ptt_run;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      output_enable <= 1'b0;
      control_packets_enable <= 1'b0;
      terminated <= 1'b0;
      adapter_switch_enable <= 1'b0;
    end else begin
      // Output goes off as soon as a cause is seen: a cycle before the first packet edge, in the same cycle as the symbol strobe
      output_enable <= (state == ptt_pkg::ptt_run) && !any_cond && startup_done;
      control_packets_enable <= (state == ptt_pkg::ptt_run) && !any_cond;
      terminated <= (state == ptt_pkg::ptt_done);
      adapter_switch_enable <= (state == ptt_pkg::ptt_done) && adapter_cause;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      low_power_boost_a <= 1'b0;
      low_power_boost_b <= 1'b0;
    end else if (term_resistor_present) begin
      low_power_boost_a <= !iout_above_100ma;
      low_power_boost_b <= !iout_above_350ma;
    end else begin
      // Pins fall back to power-good and pad-detect
      low_power_boost_a <= output_enable;
      low_power_boost_b <= pad_present;
    end
  end

  // Limit is held off outside modulation so steady loads see no clamp
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      comm_limit_enable <= 1'b0;
      comm_limit_minus <= 1'b0;
    end else begin
      comm_limit_enable <= packet_mode && !comm_current_limit_select && tx_bus.busy
                           && iout_above_100ma;
      comm_limit_minus <= iout_above_400ma;
    end
  end
endmodule

/* logic/ptt_params.svh */
/*
  Constants for the power transfer termination controller: register offsets, reset values,
  reason codes, symbol codes and timing counts.
  Assumes inclusion by bare name from the design files.
*/
`ifndef PTT_PARAMS_SVH
`define PTT_PARAMS_SVH

`define PTT_REG_VOUT_SET 8'h01
`define PTT_VOUT_SET_RESET 8'h00
`define PTT_VOUT_FIELD_MSB 2
`define PTT_VOUT_FIELD_LSB 0

`define PTT_REASON_ADAPTER 8'h00
`define PTT_REASON_CHARGED 8'h01
`define PTT_REASON_FAULT 8'h02
`define PTT_REASON_OVER_TEMP 8'h03
`define PTT_REASON_OVER_VOLT 8'h04
`define PTT_EPT_HEADER 8'h02

`define PTT_SYM_INC 3'h0
`define PTT_SYM_DEC 3'h1
`define PTT_SYM_NO_CHANGE 3'h2
`define PTT_SYM_EOC 3'h3
`define PTT_SYM_MSG_BIT 3'h4
`define PTT_SYM_RESERVED 3'h5

`define PTT_STARTUP_CEP_LIMIT 7'h40
`define PTT_CLK_PERIOD_PS 5000
`define PTT_HALF_BIT_PS 250000000
`define PTT_HALF_BIT_CYCLES (`PTT_HALF_BIT_PS / `PTT_CLK_PERIOD_PS)
`define PTT_PREAMBLE_BITS 11
`define PTT_FRAME_BITS 44

`endif

/* logic/ptt_pkg.sv */
/*
  Types of the power transfer termination controller.
  Assumes ptt_params.svh holds the numeric constants.
*/
package ptt_pkg;
  typedef enum logic [1:0] {
    ptt_run = 2'h0,
    ptt_send = 2'h1,
    ptt_done = 2'h3
  } ptt_state_type;
  typedef enum logic [1:0] {
    ptt_tx_idle = 2'h0,
    ptt_tx_frame = 2'h1,
    ptt_tx_finish = 2'h3
  } ptt_tx_state_type;
endpackage

/* logic/ptt_tx.sv */
/*
  Transmit sequencer: one end-power-transfer packet in differential bi-phase at 2 kb/s,
  or one symbol strobe.
  Assumes start is a one-cycle pulse taken only while idle.
*/
`timescale 1ns/1ps
`include "ptt_params.svh"
module ptt_tx #(
  parameter int HALF_BIT_CYCLES = `PTT_HALF_BIT_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  ptt_tx_if.tx bus,
  output logic mod_level,
  output logic symbol_strobe,
  output logic [2:0] symbol_code
);
  ptt_pkg::ptt_tx_state_type state;
  logic [`PTT_FRAME_BITS-1:0] frame;
  logic [5:0] bit_index;
  logic half;
  logic [16:0] tick;
  logic [7:0] check;
  logic tick_end;

  assign check = `PTT_EPT_HEADER ^ bus.reason;
  assign tick_end = (tick == 17'(HALF_BIT_CYCLES - 1));
  assign bus.busy = (state != ptt_pkg::ptt_tx_idle);

  // Byte: start 0, data LSB first, odd parity, stop 1
  function automatic logic [10:0] ptt_byte(input logic [7:0] b);
    ptt_byte = {1'b1, ~^b, b, 1'b0};
  endfunction

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state <= ptt_pkg::ptt_tx_idle;
      frame <= '0;
      bit_index <= 6'h00;
      half <= 1'b0;
      tick <= 17'h00000;
      bus.done <= 1'b0;
    end else begin
      bus.done <= 1'b0;
      case (state)
        ptt_pkg::ptt_tx_idle: begin
          if (bus.start && bus.packet_mode) begin
            frame <= {ptt_byte(check), ptt_byte(bus.reason), ptt_byte(`PTT_EPT_HEADER),
                      {`PTT_PREAMBLE_BITS{1'b1}}};
            bit_index <= 6'h00;
            half <= 1'b0;
            tick <= 17'h00000;
            state <= ptt_pkg::ptt_tx_frame;
          end else if (bus.start) begin
            state <= ptt_pkg::ptt_tx_finish;
          end
        end
        ptt_pkg::ptt_tx_frame: begin
          if (tick_end) begin
            tick <= 17'h00000;
            half <= ~half;
            if (half) begin
              if (bit_index == 6'(`PTT_FRAME_BITS - 1)) begin
                state <= ptt_pkg::ptt_tx_finish;
              end
              bit_index <= bit_index + 6'h01;
            end
          end else begin
            tick <= tick + 17'h00001;
          end
        end
        ptt_pkg::ptt_tx_finish: begin
          bus.done <= 1'b1;
          state <= ptt_pkg::ptt_tx_idle;
        end
        default: state <= ptt_pkg::ptt_tx_idle;
      endcase
    end
  end

  // Edge at every bit start, and mid-bit for a one
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      mod_level <= 1'b0;
    end else if (state == ptt_pkg::ptt_tx_frame && tick == 17'h00000 && (!half || frame[bit_index])) begin
      mod_level <= ~mod_level;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      symbol_strobe <= 1'b0;
      symbol_code <= `PTT_SYM_NO_CHANGE;
    end else begin
      symbol_strobe <= bus.start && !bus.packet_mode && state == ptt_pkg::ptt_tx_idle;
      if (bus.start && !bus.packet_mode) begin
        symbol_code <= bus.symbol;
      end
    end
  end
endmodule

/* logic/ptt_tx_if.sv */
/*
  Carrier between the decision logic and the transmit sequencer.
  Assumes both ends share clk and reset_n.
*/
`timescale 1ns/1ps
interface ptt_tx_if;
  logic start;
  logic packet_mode;
  logic [7:0] reason;
  logic [2:0] symbol;
  logic busy;
  logic done;
  modport ctrl (output start, output packet_mode, output reason, output symbol, input busy, input done);
  modport tx (input start, input packet_mode, input reason, input symbol, output busy, output done);
endinterface

/* testbench/ptt_ctrl_properties.sv */
/*
  Timing relations of the termination controller.
  Assumes it is bound to ptt_ctrl and sees only its ports.
*/
`timescale 1ns/1ps
module ptt_ctrl_properties (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic packet_mode,
  input wire logic adapter_above_enable,
  input wire logic temp_sense_high,
  input wire logic control_pin_high,
  input wire logic junction_over_150c,
  input wire logic limit_resistor_low,
  input wire logic term_above_limit_sense,
  input wire logic term_resistor_present,
  input wire logic iout_above_100ma,
  input wire logic iout_above_350ma,
  input wire logic comm_current_limit_select,
  input wire logic pad_present,
  input wire logic reg_write,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [2:0] output_voltage_feedback,
  input wire logic output_enable,
  input wire logic control_packets_enable,
  input wire logic low_power_boost_a,
  input wire logic low_power_boost_b,
  input wire logic comm_limit_enable,
  input wire logic symbol_strobe,
  input wire logic [2:0] symbol_code,
  input wire logic terminated,
  input wire logic [7:0] end_power_transfer
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  logic hi_pri;
  assign hi_pri = adapter_above_enable | temp_sense_high | (control_pin_high & ~term_resistor_present);
  adapter_first_a: assert property (control_packets_enable && adapter_above_enable
    |=> !output_enable && end_power_transfer == 8'h00) else $error("adapter termination");
  fault_pkt_a: assert property (control_packets_enable && packet_mode && !hi_pri
    && (junction_over_150c || limit_resistor_low) |=> end_power_transfer == 8'h02) else $error("fault code");
  sym_eoc_a: assert property (control_packets_enable && !packet_mode && term_above_limit_sense
    |=> symbol_strobe && symbol_code == 3'h3) else $error("end of charge symbol");
  // Sampled reset keeps the release edge out, where the pins still hold their reset level
  boost_band_a: assert property (reset_n && term_resistor_present
    |=> low_power_boost_a == !$past(iout_above_100ma)
    && low_power_boost_b == !$past(iout_above_350ma)) else $error("boost band");
  boost_fallback_a: assert property (!term_resistor_present
    |=> low_power_boost_b == $past(pad_present)) else $error("pad detect role");
  limit_gate_a: assert property (!packet_mode || comm_current_limit_select || !iout_above_100ma
    |=> !comm_limit_enable) else $error("comm limit gate");
  final_state_a: assert property (terminated
    |=> terminated && !output_enable && $stable(end_power_transfer)) else $error("left final state");
  vout_set_a: assert property (reg_write && reg_addr == 8'h01
    |=> ##1 output_voltage_feedback == $past(reg_wdata[2:0], 2)) else $error("feedback code");
  reason_range_a: assert property (end_power_transfer <= 8'h04) else $error("reason out of range");
endmodule
bind ptt_ctrl ptt_ctrl_properties u_props (.*);

/* testbench/ptt_tx_peer.sv */
/*
  Transmitter-side observer: counts modulator transitions and keeps the last strobed symbol.
  Assumes the receiver outputs are registered on clk.
*/
`timescale 1ns/1ps
module ptt_tx_peer (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic mod_level,
  input wire logic symbol_strobe,
  input wire logic [2:0] symbol_code,
  output int edges,
  output logic [2:0] last_symbol
);
  logic prev_level;
  // Counting edges exposes a lost mid-bit flip of the bi-phase code
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      edges <= 0;
      prev_level <= 1'h0;
    end else begin
      prev_level <= mod_level;
      if (mod_level != prev_level) edges <= edges + 1;
    end
  end
  // Only strobed codes are taken as received
  always_ff @(posedge clk) begin
    if (!reset_n) last_symbol <= 3'h7;
    else if (symbol_strobe) last_symbol <= symbol_code;
  end
endmodule

/* testbench/tb.sv */
/*
  Self-checking bench of the termination controller.
  Assumes a short bit time (HALF_BIT_CYCLES 4) and the observer model.
*/
`timescale 1ns/1ps
`include "ptt_params.svh"
module tb;
  logic clk = 1'h0;
  logic reset_n = 1'h0;
  logic packet_mode, startup_done, cep_sent, rectifier_node_at_target, adapter_above_enable;
  logic temp_sense_high, control_pin_high, control_pin_low, junction_over_150c, limit_resistor_low;
  logic temp_sense_hot, term_above_limit_sense, term_resistor_present, iout_above_100ma;
  logic iout_above_350ma, iout_above_400ma, comm_current_limit_select, pad_present, reg_write;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, end_power_transfer;
  logic [2:0] output_voltage_feedback, symbol_code, last_symbol;
  logic output_enable, adapter_switch_enable, control_packets_enable, low_power_boost_a;
  logic low_power_boost_b, comm_limit_enable, comm_limit_minus, mod_level, symbol_strobe, terminated;
  int edges;
  int n_errors = 0;
  int num_checks = 0;

  always #2.5 clk = ~clk;

  ptt_ctrl #(.HALF_BIT_CYCLES(4)) DUT (.*);
  ptt_tx_peer u_peer (.clk(clk), .reset_n(reset_n), .mod_level(mod_level), .symbol_strobe(symbol_strobe),
    .symbol_code(symbol_code), .edges(edges), .last_symbol(last_symbol));

  task automatic chk(input bit ok, input string msg);
    num_checks++;
    if (!ok) begin
      n_errors++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask

  task automatic rst();
    @(posedge clk);
    {reset_n, cep_sent, adapter_above_enable, temp_sense_high, control_pin_high, control_pin_low,
      junction_over_150c, limit_resistor_low, temp_sense_hot, term_above_limit_sense, iout_above_100ma,
      iout_above_350ma, iout_above_400ma, comm_current_limit_select, pad_present, reg_write,
      reg_addr, reg_wdata} <= '0;
    {packet_mode, startup_done, rectifier_node_at_target, term_resistor_present} <= 4'hF;
    repeat (8) @(posedge clk);
    reset_n <= 1'h1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_write <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_write <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    @(posedge clk);
    @(negedge clk);
    chk(reg_rdata === e, "register read");
  endtask

  task automatic cep();
    @(posedge clk);
    cep_sent <= 1'h1;
    @(posedge clk);
    cep_sent <= 1'h0;
  endtask

  // Frame edges: one per bit start plus one per mid-bit of a one
  function automatic int exp_edges(input logic [7:0] r);
    logic [7:0] b;
    int n;
    n = 55;
    for (int i = 0; i < 3; i++) begin
      b = (i == 0) ? `PTT_EPT_HEADER : (i == 1) ? r : (`PTT_EPT_HEADER ^ r);
      n += $countones(b) + int'(~^b) + 1;
    end
    return n;
  endfunction

  task automatic term(input logic [7:0] r, input logic sel);
    logic saw;
    logic mn;
    saw = 1'h0;
    mn = 1'h0;
    rst();
    // Let the idle state register first, so the cause meets an open packet path
    repeat (2) @(posedge clk);
    comm_current_limit_select <= sel;
    iout_above_100ma <= 1'h1;
    iout_above_350ma <= (r == 8'h03);
    iout_above_400ma <= (r == 8'h03);
    case (r)
      8'h00: adapter_above_enable <= 1'h1;
      8'h01: begin
        temp_sense_high <= sel;
        term_resistor_present <= sel;
        control_pin_high <= !sel;
      end
      8'h02: begin
        junction_over_150c <= 1'h1;
        limit_resistor_low <= 1'h1;
        temp_sense_hot <= 1'h1;
      end
      8'h03: control_pin_low <= 1'h1;
      default: begin
        startup_done <= 1'h0;
        rectifier_node_at_target <= 1'h0;
        repeat (63) cep();
        repeat (4) @(negedge clk);
        chk(control_packets_enable === 1'h1, "early over-voltage");
        cep();
      end
    endcase
    for (int k = 0; k < 1000 && terminated !== 1'h1; k++) begin
      @(negedge clk);
      if (comm_limit_enable === 1'h1) saw = 1'h1;
      if (comm_limit_enable === 1'h1) mn = comm_limit_minus;
    end
    repeat (2) @(negedge clk);
    chk(terminated === 1'h1, "no termination");
    chk(end_power_transfer === r, "reason code");
    chk(output_enable === 1'h0, "output on");
    chk(edges === exp_edges(r), "bi-phase edges");
    chk(saw === !sel, "comm limit");
    chk(mn === (!sel && r == 8'h03), "comm limit band");
    chk(adapter_switch_enable === (r == 8'h00), "adapter switch");
  endtask

  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    rst();
    rd(8'h01, 8'h00);
    chk(output_voltage_feedback === 3'h0, "feedback reset");
    wr(8'h01, 8'h05);
    rd(8'h01, 8'h05);
    chk(output_voltage_feedback === 3'h5, "feedback code");
    wr(8'h02, 8'hFF);
    rd(8'h02, 8'h00);
    rd(8'h01, 8'h05);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      iout_above_100ma <= (i > 0);
      iout_above_350ma <= (i > 1);
      repeat (3) @(negedge clk);
      chk(low_power_boost_a === (i == 0) && low_power_boost_b === (i < 2), "boost band");
    end
    @(posedge clk);
    term_resistor_present <= 1'h0;
    pad_present <= 1'h1;
    repeat (3) @(negedge clk);
    chk(low_power_boost_b === 1'h1, "pad detect role");
    chk(low_power_boost_a === 1'h1, "power good role");
    term(8'h00, 1'h0);
    term(8'h01, 1'h1);
    term(8'h01, 1'h0);
    term(8'h02, 1'h0);
    term(8'h03, 1'h0);
    term(8'h04, 1'h0);
    rst();
    term_above_limit_sense <= 1'h1;
    // With the termination resistor fitted a high control pin must not end the transfer
    control_pin_high <= 1'h1;
    repeat (20) @(negedge clk);
    chk(terminated === 1'h0 && control_packets_enable === 1'h1, "packet mode end");
    @(posedge clk);
    packet_mode <= 1'h0;
    repeat (6) @(negedge clk);
    chk(terminated === 1'h1 && last_symbol === `PTT_SYM_EOC, "end of charge");
    chk(edges === 0, "packet in symbol mode");
    complete_run();
  end

  initial begin
    #100000;
    n_errors++;
    complete_run();
  end
endmodule
